// >>> psc_link_path.sv
// loopback routing and priority-2 credit gate
`timescale 1ns/100ps
module psc_link_path
	import psc_pkg::*;
(
	// clock and reset
	input  wire logic                 sys_clk_in,
	input  wire logic                 reset_n_in,
	// settings
	input  wire logic                 loopback_in,
	input  wire logic [2:0]           prio2_credit_threshold_in,
	input  wire logic                 single_lane_port_buffering_in,
	// logical layer side
	input  wire logic [PSC_PKT_W-1:0] tx_data_in,
	input  wire logic                 tx_valid_in,
	output logic      [PSC_PKT_W-1:0] rx_data_out,
	output logic                      rx_valid_out,
	input  wire logic [3:0]           free_buffers_in,
	output logic                      prio2_send_ok_out,
	// serializer side, parallel data on the system clock
	output logic      [PSC_PKT_W-1:0] serdes_tx_data_out,
	output logic                      serdes_tx_valid_out,
	input  wire logic [PSC_PKT_W-1:0] serdes_rx_data_in,
	input  wire logic                 serdes_rx_valid_in
);

	// ==========================================================
	// state
	psc_path_s cur;
	psc_path_s nxt;
	logic [3:0] need;

	// next state; loopback silences the serializer so the far end sees no echo
	always_comb begin
		nxt = cur;
		nxt.serdes_tx_data = tx_data_in;
		nxt.serdes_tx_valid = tx_valid_in && !loopback_in;
		if (loopback_in) begin
			nxt.rx_data = tx_data_in;
			nxt.rx_valid = tx_valid_in;
		end else begin
			nxt.rx_data = serdes_rx_data_in;
			nxt.rx_valid = serdes_rx_valid_in;
		end
		// outside single-lane mode only one free buffer is asked for
		need = single_lane_port_buffering_in ?
			psc_required_count(prio2_credit_threshold_in) : PSC_MIN_CREDITS;
		nxt.send_ok = (free_buffers_in >= need);
	end

	// register the copy
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cur <= '0;
		end else begin
			cur <= nxt;
		end
	end

	assign serdes_tx_data_out  = cur.serdes_tx_data;
	assign serdes_tx_valid_out = cur.serdes_tx_valid;
	assign rx_data_out         = cur.rx_data;
	assign rx_valid_out        = cur.rx_valid;
	assign prio2_send_ok_out   = cur.send_ok;

	// ==========================================================
	// checks
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);

	loop_route_a: assert property (loopback_in && tx_valid_in |=>
		rx_valid_out && !serdes_tx_valid_out && rx_data_out == $past(tx_data_in))
		else $error("loopback did not route transmit data to receive");

	normal_route_a: assert property (!loopback_in |=>
		rx_valid_out == $past(serdes_rx_valid_in) && rx_data_out == $past(serdes_rx_data_in))
		else $error("normal receive path broken");

	credit_gate_a: assert property (single_lane_port_buffering_in |=>
		prio2_send_ok_out ==
		($past(free_buffers_in) >= psc_required_count($past(prio2_credit_threshold_in))))
		else $error("priority-2 credit threshold misapplied");

	credit_bypass_a: assert property (!single_lane_port_buffering_in |=>
		prio2_send_ok_out == ($past(free_buffers_in) != 4'h0))
		else $error("threshold acted outside single-lane mode");

endmodule // psc_link_path

// >>> psc_pkg.sv
// constants, types and helpers for the peripheral settings control block
// What this block does
// - inhibit bit keeps memories awake in shutdown
// - loopback bit routes transmit data to receive
// - unlocked: writes reach normally read-only registers
// - locked: writes to read-only registers ignored
// - threshold sets free buffers needed for priority-2
// - code n requires n plus one buffers
// - threshold applies only in single-lane buffering
package psc_pkg;

	// ==========================================================
	// bus and register map
	localparam int              PSC_ADDR_W        = 12;
	localparam logic [11:0]     PSC_SETTINGS_OFF  = 12'h000;
	localparam logic [11:0]     PSC_DEVCFG_OFF    = 12'h004;

	// ==========================================================
	// field positions of the settings word
	localparam int              PSC_INHIBIT_BIT   = 26;
	localparam int              PSC_LOOPBACK_BIT  = 25;
	localparam int              PSC_LOCK_BIT      = 24;
	localparam int              PSC_THR_LSB       = 18;
	localparam int              PSC_LANE_BIT      = 8;
	localparam logic [31:0]     PSC_SETTINGS_MASK = 32'h071C_0100;

	// ==========================================================
	// values after reset and counts
	localparam logic [2:0]      PSC_THR_RESET     = 3'h1;
	localparam logic [31:0]     PSC_DEVCFG_RESET  = 32'h0000_0000;
	localparam logic [3:0]      PSC_MIN_CREDITS   = 4'h1;
	localparam int              PSC_PKT_W         = 32;

	// ==========================================================
	// types
	typedef struct packed {
		logic                   mem_sleep_inhibit;
		logic                   loopback;
		logic                   init_lock;
		logic [2:0]             prio2_credit_threshold;
		logic                   single_lane_port_buffering;
	} psc_settings_s;

	typedef struct packed {
		psc_settings_s          settings;
		logic [31:0]            device_config;
		logic [31:0]            prdata;
		logic                   pready;
		logic                   pslverr;
		logic                   mem_sleep;
	} psc_regs_s;

	typedef struct packed {
		logic [PSC_PKT_W-1:0]   serdes_tx_data;
		logic                   serdes_tx_valid;
		logic [PSC_PKT_W-1:0]   rx_data;
		logic                   rx_valid;
		logic                   send_ok;
	} psc_path_s;

	// ==========================================================
	// helpers
	// buffers a priority-2 packet needs for a threshold code
	function automatic logic [3:0] psc_required_count(input logic [2:0] code);
		return {1'b0, code} + 4'h1;
	endfunction

	// settings as the bus sees them, reserved bits zero
	function automatic logic [31:0] psc_pack(input psc_settings_s s);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[PSC_INHIBIT_BIT]                 = s.mem_sleep_inhibit;
		w[PSC_LOOPBACK_BIT]                = s.loopback;
		w[PSC_LOCK_BIT]                    = s.init_lock;
		w[PSC_THR_LSB +: 3]                = s.prio2_credit_threshold;
		w[PSC_LANE_BIT]                    = s.single_lane_port_buffering;
		return w;
	endfunction

	// byte-lane merge of a write into an old word
	function automatic logic [31:0] psc_merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] strb);
		logic [31:0] w;
		w = old_w;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				w[8*i +: 8] = new_w[8*i +: 8];
			end
		end
		return w;
	endfunction

endpackage

// >>> psc_settings_top.sv
// apb register bank for peripheral settings, with power and credit control
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/100ps
module psc_settings_top
	import psc_pkg::*;
#(
	parameter logic [31:0] DEVCFG_RESET = PSC_DEVCFG_RESET
)(
	// clock and reset
	input  wire logic                  sys_clk_in,
	input  wire logic                  reset_n_in,
	// apb slave
	input  wire logic [PSC_ADDR_W-1:0] paddr_in,
	input  wire logic                  psel_in,
	input  wire logic                  penable_in,
	input  wire logic                  pwrite_in,
	input  wire logic [31:0]           pwdata_in,
	input  wire logic [3:0]            pstrb_in,
	output logic      [31:0]           prdata_out,
	output logic                       pready_out,
	output logic                       pslverr_out,
	// power control
	input  wire logic                  shutdown_in,
	output logic                       mem_sleep_out,
	// protected configuration seen by the rest of the peripheral
	output logic      [31:0]           device_config_out,
	// logical layer side
	input  wire logic [PSC_PKT_W-1:0]  tx_data_in,
	input  wire logic                  tx_valid_in,
	output logic      [PSC_PKT_W-1:0]  rx_data_out,
	output logic                       rx_valid_out,
	input  wire logic [3:0]            free_buffers_in,
	output logic                       prio2_send_ok_out,
	// serializer side
	output logic      [PSC_PKT_W-1:0]  serdes_tx_data_out,
	output logic                       serdes_tx_valid_out,
	input  wire logic [PSC_PKT_W-1:0]  serdes_rx_data_in,
	input  wire logic                  serdes_rx_valid_in
);

	// ==========================================================
	// state and decode
	psc_regs_s   cur;
	psc_regs_s   nxt;
	logic        access_first;
	logic        commit;
	logic        hit_settings;
	logic        hit_devcfg;
	logic [31:0] wr_word;

	assign hit_settings = (paddr_in == PSC_SETTINGS_OFF);
	assign hit_devcfg   = (paddr_in == PSC_DEVCFG_OFF);
	// first access cycle prepares the answer, the pready cycle commits it
	assign access_first = psel_in && penable_in && !cur.pready;
	assign commit       = psel_in && penable_in && cur.pready && pwrite_in;

	// ==========================================================
	// next state
	always_comb begin
		nxt = cur;
		wr_word = 32'h0000_0000;
		nxt.pready = access_first;
		if (access_first) begin
			nxt.pslverr = 1'b0;
			if (hit_settings) begin
				nxt.prdata = psc_pack(cur.settings);
			end else if (hit_devcfg) begin
				nxt.prdata = cur.device_config;
			end else begin
				// unmapped: zero data and an error answer
				nxt.prdata = 32'h0000_0000;
				nxt.pslverr = 1'b1;
			end
		end
		if (commit && hit_settings) begin
			// reserved bits are simply never stored
			wr_word = psc_merge(psc_pack(cur.settings), pwdata_in, pstrb_in);
			nxt.settings.mem_sleep_inhibit = wr_word[PSC_INHIBIT_BIT];
			nxt.settings.loopback = wr_word[PSC_LOOPBACK_BIT];
			// lock only sets; clearing it would reopen protected registers
			nxt.settings.init_lock = cur.settings.init_lock | wr_word[PSC_LOCK_BIT];
			nxt.settings.prio2_credit_threshold = wr_word[PSC_THR_LSB +: 3];
			nxt.settings.single_lane_port_buffering = wr_word[PSC_LANE_BIT];
		end
		if (commit && hit_devcfg && !cur.settings.init_lock) begin
			nxt.device_config = psc_merge(cur.device_config, pwdata_in, pstrb_in);
		end
		// locked writes to device_config fall through here untouched, no error
		nxt.mem_sleep = shutdown_in && !cur.settings.mem_sleep_inhibit;
	end

	// register the copy
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cur <= '0;
			cur.settings.prio2_credit_threshold <= PSC_THR_RESET;
			cur.device_config <= DEVCFG_RESET;
		end else begin
			cur <= nxt;
		end
	end

	assign prdata_out        = cur.prdata;
	assign pready_out        = cur.pready;
	assign pslverr_out       = cur.pslverr;
	assign mem_sleep_out     = cur.mem_sleep;
	assign device_config_out = cur.device_config;

	// ==========================================================
	// link datapath
	psc_link_path u_path (
		.sys_clk_in                    (sys_clk_in),
		.reset_n_in                    (reset_n_in),
		.loopback_in                   (cur.settings.loopback),
		.prio2_credit_threshold_in     (cur.settings.prio2_credit_threshold),
		.single_lane_port_buffering_in (cur.settings.single_lane_port_buffering),
		.tx_data_in                    (tx_data_in),
		.tx_valid_in                   (tx_valid_in),
		.rx_data_out                   (rx_data_out),
		.rx_valid_out                  (rx_valid_out),
		.free_buffers_in               (free_buffers_in),
		.prio2_send_ok_out             (prio2_send_ok_out),
		.serdes_tx_data_out            (serdes_tx_data_out),
		.serdes_tx_valid_out           (serdes_tx_valid_out),
		.serdes_rx_data_in             (serdes_rx_data_in),
		.serdes_rx_valid_in            (serdes_rx_valid_in)
	);

	// ==========================================================
	// checks
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);

	sleep_gate_a: assert property (shutdown_in && !cur.settings.mem_sleep_inhibit
		|=> mem_sleep_out)
		else $error("memories not put to sleep in shutdown");

	sleep_hold_a: assert property (cur.settings.mem_sleep_inhibit || !shutdown_in
		|=> !mem_sleep_out)
		else $error("memories slept while inhibited or awake");

	unlocked_write_a: assert property (commit && hit_devcfg && pstrb_in == 4'hF
		&& !cur.settings.init_lock |=> device_config_out == $past(pwdata_in))
		else $error("unlocked write to protected register lost");

	locked_write_a: assert property (cur.settings.init_lock |=>
		$stable(device_config_out) && cur.settings.init_lock)
		else $error("protected register changed after lock");

	reserved_zero_a: assert property (pready_out && $past(hit_settings)
		&& !pslverr_out |-> (prdata_out & ~PSC_SETTINGS_MASK) == 32'h0000_0000)
		else $error("reserved settings bits read non-zero");

	apb_answer_a: assert property (psel_in && penable_in && !pready_out
		|=> pready_out ##1 !pready_out)
		else $error("apb answer not a single pready cycle");

	// ==========================================================
	// answer content and error checks

	// no answer may appear without a live access phase
	idle_quiet_a: assert property (!(psel_in && penable_in) |=> !pready_out)
		else $error("pready without an access");

	// software may sample prdata late, so it must hold between answers
	answer_hold_a: assert property (!access_first |=> $stable(prdata_out) && $stable(pslverr_out))
		else $error("read data moved between answers");

	// unmapped offsets answer with error and zero data
	unmapped_err_a: assert property (access_first && !hit_settings && !hit_devcfg
		|=> pslverr_out && prdata_out == 32'h0000_0000)
		else $error("unmapped access not refused");

	// mapped offsets never raise an error, even when locked
	mapped_ok_a: assert property (access_first && (hit_settings || hit_devcfg)
		|=> !pslverr_out)
		else $error("mapped access answered with error");

	// read data reflects the stored fields
	settings_read_a: assert property (access_first && hit_settings
		|=> prdata_out[PSC_THR_LSB +: 3] == $past(cur.settings.prio2_credit_threshold)
		&& prdata_out[PSC_LOCK_BIT] == $past(cur.settings.init_lock))
		else $error("settings read wrong");

	devcfg_read_a: assert property (access_first && hit_devcfg
		|=> prdata_out == $past(device_config_out))
		else $error("protected register read wrong");

	// ==========================================================
	// register store checks

	// a full-word settings write lands in the threshold, loopback and inhibit fields
	settings_store_a: assert property (commit && hit_settings && pstrb_in == 4'hF
		|=> cur.settings.prio2_credit_threshold == $past(pwdata_in[PSC_THR_LSB +: 3])
		&& cur.settings.loopback == $past(pwdata_in[PSC_LOOPBACK_BIT])
		&& cur.settings.mem_sleep_inhibit == $past(pwdata_in[PSC_INHIBIT_BIT]))
		else $error("settings write not stored");

	lock_set_a: assert property (commit && hit_settings && pstrb_in[3]
		&& pwdata_in[PSC_LOCK_BIT] |=> cur.settings.init_lock)
		else $error("lock bit did not take");

	// the lock only rises through a settings write
	lock_quiet_a: assert property (!cur.settings.init_lock && !(commit && hit_settings)
		|=> !cur.settings.init_lock)
		else $error("lock set without a settings write");

	settings_quiet_a: assert property (!(commit && hit_settings) |=> $stable(cur.settings))
		else $error("settings changed without a write");

	devcfg_quiet_a: assert property (!(commit && hit_devcfg) |=> $stable(device_config_out))
		else $error("protected register changed without a write");

	// reads and unmapped writes leave every register alone
	read_keep_a: assert property (psel_in && penable_in && !pwrite_in
		|=> $stable(cur.settings) && $stable(device_config_out))
		else $error("read access changed a register");

	stray_write_a: assert property (commit && !hit_settings && !hit_devcfg
		|=> $stable(cur.settings) && $stable(device_config_out))
		else $error("unmapped write changed a register");

	// byte lanes without a strobe keep their old contents
	lane_keep_a: assert property (commit && hit_devcfg && pstrb_in == 4'h5
		&& !cur.settings.init_lock |=>
		device_config_out[31:24] == $past(device_config_out[31:24])
		&& device_config_out[23:16] == $past(pwdata_in[23:16])
		&& device_config_out[15:8] == $past(device_config_out[15:8]))
		else $error("unstrobed byte lanes of protected register changed");

	// ==========================================================
	// settings seen at the link

	// in single-lane mode the threshold must hold back a send whenever buffers run short
	thr_block_a: assert property (cur.settings.single_lane_port_buffering
		&& free_buffers_in < psc_required_count(cur.settings.prio2_credit_threshold)
		|=> !prio2_send_ok_out)
		else $error("priority-2 send allowed below threshold");

	loop_quiet_a: assert property (cur.settings.loopback |=> !serdes_tx_valid_out)
		else $error("serializer driven during loopback");

endmodule // psc_settings_top

// >>> tb.sv
// self-checking bench for the peripheral settings register bank
`timescale 1ns/100ps
module tb;
	import psc_pkg::*;
	// ==========================================================
	// stimulus and observed signals
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [31:0] pwd = 32'h0;
	logic [3:0]  pstrb = 4'hF;
	logic        shut = 1'b0;
	logic [31:0] txd = 32'h0;
	logic        txv = 1'b0;
	logic [3:0]  free = 4'h0;
	logic [31:0] srxd = 32'h0;
	logic        srxv = 1'b0;
	logic [31:0] prdata, devcfg, rxd, stxd, rd, v;
	logic        pready, pslverr, msleep, rxv, ok, stxv, err;
	logic [2:0]  code;
	logic        lane;
	int          bad_count = 0;
	int          num_checks = 0;
	int          cyc = 0;

	psc_settings_top dut_u (
		.sys_clk_in(clk), .reset_n_in(rst_n), .paddr_in(paddr), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .pwdata_in(pwd), .pstrb_in(pstrb),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.shutdown_in(shut), .mem_sleep_out(msleep), .device_config_out(devcfg),
		.tx_data_in(txd), .tx_valid_in(txv), .rx_data_out(rxd), .rx_valid_out(rxv),
		.free_buffers_in(free), .prio2_send_ok_out(ok), .serdes_tx_data_out(stxd),
		.serdes_tx_valid_out(stxv), .serdes_rx_data_in(srxd), .serdes_rx_valid_in(srxv)
	);

	// ==========================================================
	// clock and hang guard
	always #10 clk = ~clk;
	// ceiling well above the few hundred cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			bad_count++;
			finish_test();
		end
	end

	// ==========================================================
	// shared tasks and expectations
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwd <= d;
		pstrb <= s;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		if (n >= 16) begin
			bad_count++;
			finish_test();
		end
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	// registered outputs settle one edge after the inputs land
	task automatic settle();
		@(posedge clk);
		@(posedge clk);
		@(negedge clk);
	endtask

	function automatic logic exp_ok(input logic [3:0] f, input logic [2:0] c, input logic l);
		return l ? (f > {1'b0, c}) : (f != 4'h0);
	endfunction

	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(32'h1edc));
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, PSC_SETTINGS_OFF, 32'h0, 4'hF);
		chk(rd, 32'h0004_0000);
		apb(1'b0, PSC_DEVCFG_OFF, 32'h0, 4'hF);
		chk(rd, PSC_DEVCFG_RESET);
		// every bit but the lock written; only real fields stick
		apb(1'b1, PSC_SETTINGS_OFF, 32'hFEFF_FFFF, 4'hF);
		apb(1'b0, PSC_SETTINGS_OFF, 32'h0, 4'hF);
		chk(rd, 32'h061C_0100);
		chk({31'h0, err}, 32'h0);
		$display("test reset and reserved done");
		// memory sleep with and without the inhibit bit
		shut <= 1'b1;
		repeat (3) settle();
		chk({31'h0, msleep}, 32'h0);
		apb(1'b1, PSC_SETTINGS_OFF, 32'h0, 4'hF);
		repeat (2) settle();
		chk({31'h0, msleep}, 32'h1);
		@(posedge clk);
		shut <= 1'b0;
		$display("test memory sleep done");
		// loopback on then off, serializer side always carries other data
		for (int lb = 1; lb >= 0; lb--) begin
			apb(1'b1, PSC_SETTINGS_OFF, lb[0] ? 32'h0200_0000 : 32'h0, 4'hF);
			for (int i = 0; i < 6; i++) begin
				v = $urandom;
				@(posedge clk);
				txd <= v;
				txv <= 1'b1;
				srxd <= ~v;
				srxv <= 1'b1;
				settle();
				chk(rxd, lb[0] ? v : ~v);
				chk({31'h0, rxv}, 32'h1);
				chk({31'h0, stxv}, lb[0] ? 32'h0 : 32'h1);
				chk(stxd, v);
			end
		end
		@(posedge clk);
		txv <= 1'b0;
		srxv <= 1'b0;
		$display("test loopback done");
		// threshold codes, every code first, then random mix of modes
		for (int i = 0; i < 40; i++) begin
			code = (i < 8) ? i[2:0] : 3'($urandom % 8);
			lane = (i < 8) ? 1'b1 : 1'($urandom % 2);
			apb(1'b1, PSC_SETTINGS_OFF, {11'h0, code, 9'h0, lane, 8'h0}, 4'hF);
			free <= (i < 8) ? {1'b0, code} + 4'(i % 2) : 4'($urandom % 9);
			settle();
			chk({31'h0, ok}, {31'h0, exp_ok(free, code, lane)});
		end
		apb(1'b0, PSC_SETTINGS_OFF, 32'h0, 4'hF);
		chk(rd, {11'h0, code, 9'h0, lane, 8'h0});
		$display("test credit threshold done");
		// protected register writable while unlocked, byte lanes honoured
		v = $urandom;
		apb(1'b1, PSC_DEVCFG_OFF, v, 4'hF);
		apb(1'b0, PSC_DEVCFG_OFF, 32'h0, 4'hF);
		chk(rd, v);
		apb(1'b1, PSC_DEVCFG_OFF, 32'h0, 4'hF);
		apb(1'b1, PSC_DEVCFG_OFF, 32'hFFFF_FFFF, 4'h5);
		apb(1'b0, PSC_DEVCFG_OFF, 32'h0, 4'hF);
		chk(rd, 32'h00FF_00FF);
		chk(devcfg, 32'h00FF_00FF);
		// unmapped place refused
		apb(1'b1, 12'h008, 32'hFFFF_FFFF, 4'hF);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, 12'h008, 32'h0, 4'hF);
		chk(rd, 32'h0);
		chk({31'h0, err}, 32'h1);
		// lock, then writes to the protected register are ignored
		apb(1'b1, PSC_SETTINGS_OFF, 32'h0100_0000, 4'hF);
		apb(1'b1, PSC_DEVCFG_OFF, $urandom, 4'hF);
		apb(1'b0, PSC_DEVCFG_OFF, 32'h0, 4'hF);
		chk(rd, 32'h00FF_00FF);
		apb(1'b1, PSC_SETTINGS_OFF, 32'h0, 4'hF);
		apb(1'b0, PSC_SETTINGS_OFF, 32'h0, 4'hF);
		chk(rd, 32'h0100_0000);
		$display("test protection and lock done");
		finish_test();
	end
endmodule // tb
